// File: common/wdcg_pkg.sv
// Shared constants and types of the watchdog control and status block.
`default_nettype none

package wdcg_pkg;

  // Bus geometry.
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned IDX_W  = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CTRL = 16'hffb1;
  localparam logic [IDX_W-1:0] IDX_CNT  = 16'hffb2;
  localparam logic [IDX_W-1:0] IDX_STAT = 16'hffb3;
  localparam logic [IDX_W-1:0] IDX_MASK = 16'hffb4;

  // Field positions of the control and status byte.
  localparam int unsigned BIT_CNT_GUARD  = 7;
  localparam int unsigned BIT_CNT_WEN    = 6;
  localparam int unsigned BIT_CTRL_GUARD = 5;
  localparam int unsigned BIT_CTRL_WEN   = 4;
  localparam int unsigned BIT_RUN_GUARD  = 3;
  localparam int unsigned BIT_RUN        = 2;
  localparam int unsigned BIT_FLAG_GUARD = 1;
  localparam int unsigned BIT_FLAG       = 0;
  localparam logic [7:0]  GUARD_MASK     = 8'haa;

  // Reset values of the writable control bits.
  localparam logic RST_CNT_WEN  = 1'h0;
  localparam logic RST_CTRL_WEN = 1'h0;
  localparam logic RST_RUN      = 1'h0;

  // Interrupt status and mask layout.
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_OVF     = 0;
  localparam int unsigned IRQ_REJ     = 1;
  localparam logic [IRQ_W-1:0] RST_MASK = 2'h0;

  // Counter and its prescaler.
  localparam int unsigned CNT_W     = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  localparam int unsigned TICK_W    = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = 4'hf;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cnt_wen;
    logic ctrl_wen;
    logic run;
    logic rst_flag;
  } wdcg_ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } wdcg_wreq_s;

  typedef enum logic [3:0] {
    WS_IDLE   = 4'b0001,
    WS_HAVE_A = 4'b0010,
    WS_HAVE_W = 4'b0100,
    WS_RESP   = 4'b1000
  } wdcg_wstate_e;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_RESP = 2'b10
  } wdcg_rstate_e;

endpackage

`default_nettype wire

// File: hw/wdcg_guard_bit.sv
// One protected control bit that changes only under its guard and enable.
`default_nettype none

module wdcg_guard_bit #(
  parameter logic RST = 1'b0
) (
  input  wire logic aclk,    // System clock.
  input  wire logic aresetn, // Synchronous reset, active low.
  input  wire logic wr,      // Whole-byte write to the register.
  input  wire logic allow,   // Enable condition for this bit.
  input  wire logic guard,   // Written guard bit; 0 opens the bit.
  input  wire logic din,     // Written value of this bit.
  output logic      q        // Stored bit.
);
  import wdcg_pkg::*;

  logic q_d;

  assign q_d = (wr && allow && !guard) ? din : q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= q_d;
    end
  end

endmodule

`default_nettype wire

// File: hw/wdcg_counter.sv
// Watchdog up-counter with prescaler, software load and overflow pulse.
`default_nettype none

module wdcg_counter (
  input  wire logic                       aclk,     // System clock.
  input  wire logic                       aresetn,  // Synchronous reset, active low.
  input  wire logic                       run,      // Count while high.
  input  wire logic                       load,     // Load strobe, one cycle.
  input  wire logic [wdcg_pkg::CNT_W-1:0] load_val, // Value to load.
  output logic      [wdcg_pkg::CNT_W-1:0] count,    // Current count.
  output logic                            ovf       // Overflow pulse, one cycle.
);
  import wdcg_pkg::*;

  logic [TICK_W-1:0] pre_q;
  logic [TICK_W-1:0] pre_d;
  logic [CNT_W-1:0]  cnt_d;
  logic              ovf_d;
  logic              tick;

  // The prescaler restarts while stopped so every run begins on a full period.
  assign tick  = run && (pre_q == TICK_LAST);
  assign pre_d = (!run || tick) ? '0 : pre_q + 1'b1;
  assign cnt_d = load ? load_val : (tick ? count + 1'b1 : count);
  assign ovf_d = !load && tick && (count == CNT_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
      count <= '0;
      ovf   <= 1'b0;
    end else begin
      pre_q <= pre_d;
      count <= cnt_d;
      ovf   <= ovf_d;
    end
  end

endmodule

`default_nettype wire

// File: hw/wdcg_top.sv
// Watchdog control and status register with guarded writes behind AXI4-Lite.
// Overview of operation
// - Counter write enable changes only with guard 0.
// - Counter accepts writes only while enabled.
// - Control write enable changes only with guard 0.
// - Run and flag writable only under control enable.
// - Run bit changes only with its guard 0.
// - Counter counts while run, holds while stopped.
// - Run set or cleared by guarded write; reset clears.
// - Software clears the reset flag only with its guard 0.
// - Counter overflow sets the reset flag.
// - External pin or guarded zero write clears flag.
// - Guard bits always read back as one.
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none

module wdcg_top (
  input  wire logic                        aclk,                // System clock.
  input  wire logic                        aresetn,             // Synchronous reset, low.
  input  wire logic [wdcg_pkg::ADDR_W-1:0] s_axi_awaddr,        // Write address.
  input  wire logic                        s_axi_awvalid,       // Write address valid.
  output logic                             s_axi_awready,       // Write address ready.
  input  wire logic [wdcg_pkg::DATA_W-1:0] s_axi_wdata,         // Write data.
  input  wire logic [wdcg_pkg::STRB_W-1:0] s_axi_wstrb,         // Write byte strobes.
  input  wire logic                        s_axi_wvalid,        // Write data valid.
  output logic                             s_axi_wready,        // Write data ready.
  output logic      [1:0]                  s_axi_bresp,         // Write response.
  output logic                             s_axi_bvalid,        // Write response valid.
  input  wire logic                        s_axi_bready,        // Write response ready.
  input  wire logic [wdcg_pkg::ADDR_W-1:0] s_axi_araddr,        // Read address.
  input  wire logic                        s_axi_arvalid,       // Read address valid.
  output logic                             s_axi_arready,       // Read address ready.
  output logic      [wdcg_pkg::DATA_W-1:0] s_axi_rdata,         // Read data.
  output logic      [1:0]                  s_axi_rresp,         // Read response.
  output logic                             s_axi_rvalid,        // Read data valid.
  input  wire logic                        s_axi_rready,        // Read data ready.
  input  wire logic                        external_reset_pin_n, // Reset pin, low.
  output logic                             internal_reset,      // Watchdog reset pulse.
  output logic                             irq                  // Interrupt, high level.
);
  import wdcg_pkg::*;

  wdcg_wstate_e      ws_q;
  wdcg_wstate_e      ws_d;
  wdcg_rstate_e      rs_q;
  wdcg_rstate_e      rs_d;
  wdcg_wreq_s        wreq_q;
  wdcg_ctrl_s        ctrl;
  logic              commit_q;
  logic [1:0]        bresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              rd_ctrl_q;
  logic              flag_q;
  logic              flag_d;
  logic [IRQ_W-1:0]  stat_q;
  logic [IRQ_W-1:0]  stat_d;
  logic [IRQ_W-1:0]  mask_q;
  logic [IRQ_W-1:0]  mask_d;
  logic [CNT_W-1:0]  count;
  logic              ovf;

  // Write channel: address and data may arrive in either order.
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire b_hs  = s_axi_bvalid && s_axi_bready;

  assign s_axi_awready = (ws_q == WS_IDLE) || (ws_q == WS_HAVE_W);
  assign s_axi_wready  = (ws_q == WS_IDLE) || (ws_q == WS_HAVE_A);
  assign s_axi_bvalid  = (ws_q == WS_RESP) && !commit_q;
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    ws_d = ws_q;
    case (ws_q)
      WS_IDLE: begin
        if (aw_hs && w_hs) begin
          ws_d = WS_RESP;
        end else if (aw_hs) begin
          ws_d = WS_HAVE_A;
        end else if (w_hs) begin
          ws_d = WS_HAVE_W;
        end
      end
      WS_HAVE_A: begin
        if (w_hs) begin
          ws_d = WS_RESP;
        end
      end
      WS_HAVE_W: begin
        if (aw_hs) begin
          ws_d = WS_RESP;
        end
      end
      WS_RESP: begin
        if (b_hs) begin
          ws_d = WS_IDLE;
        end
      end
      default: begin
        ws_d = WS_IDLE;
      end
    endcase
  end

  wire start_commit = (ws_q != WS_RESP) && (ws_d == WS_RESP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q     <= WS_IDLE;
      commit_q <= 1'b0;
      wreq_q   <= '0;
    end else begin
      ws_q     <= ws_d;
      commit_q <= start_commit;
      if (aw_hs) begin
        wreq_q.addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
    end
  end

  // Write decode. Only lane 0 carries the byte; a write without it is ignored.
  wire [IDX_W-1:0] w_idx    = wreq_q.addr[ADDR_W-1:2];
  wire             w_ctrl   = (w_idx == IDX_CTRL);
  wire             w_cnt    = (w_idx == IDX_CNT);
  wire             w_stat   = (w_idx == IDX_STAT);
  wire             w_mask   = (w_idx == IDX_MASK);
  wire             w_mapped = w_ctrl || w_cnt || w_stat || w_mask;
  wire             lane0    = wreq_q.strb[0];
  wire [7:0]       wd       = wreq_q.data[7:0];
  wire             ctrl_wr  = commit_q && w_ctrl && lane0;
  wire             cnt_wr   = commit_q && w_cnt && lane0;
  wire             mask_wr  = commit_q && w_mask && lane0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= RESP_OKAY;
    end else if (commit_q) begin
      bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Each protected bit sees the enable as it stood before this write.
  wdcg_guard_bit #(.RST(RST_CNT_WEN)) u_cnt_wen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (ctrl_wr),
    .allow   (1'b1),
    .guard   (wd[BIT_CNT_GUARD]),
    .din     (wd[BIT_CNT_WEN]),
    .q       (ctrl.cnt_wen)
  );

  wdcg_guard_bit #(.RST(RST_CTRL_WEN)) u_ctrl_wen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (ctrl_wr),
    .allow   (1'b1),
    .guard   (wd[BIT_CTRL_GUARD]),
    .din     (wd[BIT_CTRL_WEN]),
    .q       (ctrl.ctrl_wen)
  );

  wdcg_guard_bit #(.RST(RST_RUN)) u_run (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (ctrl_wr),
    .allow   (ctrl.ctrl_wen),
    .guard   (wd[BIT_RUN_GUARD]),
    .din     (wd[BIT_RUN]),
    .q       (ctrl.run)
  );

  // The counter only loads when its write enable is already open.
  wire cnt_load = cnt_wr && ctrl.cnt_wen;
  wire cnt_rej  = cnt_wr && !ctrl.cnt_wen;

  wdcg_counter u_counter (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (ctrl.run),
    .load     (cnt_load),
    .load_val (wd),
    .count    (count),
    .ovf      (ovf)
  );

  // The flag must survive the reset that it reports, so the bus reset
  // leaves it alone; only the external pin and software clear it.
  wire flag_sw_clr = ctrl_wr && ctrl.ctrl_wen && !wd[BIT_FLAG_GUARD] && !wd[BIT_FLAG];
  wire flag_clr    = !external_reset_pin_n || flag_sw_clr;

  assign flag_d        = ovf ? 1'b1 : (flag_clr ? 1'b0 : flag_q);
  assign ctrl.rst_flag = flag_q;

  always_ff @(posedge aclk) begin
    flag_q <= flag_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= ovf;
    end
  end

  // Read channel.
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire r_hs  = s_axi_rvalid && s_axi_rready;

  assign s_axi_arready = (rs_q == RS_IDLE);
  assign s_axi_rvalid  = (rs_q == RS_RESP);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rs_d = rs_q;
    case (rs_q)
      RS_IDLE: begin
        if (ar_hs) begin
          rs_d = RS_RESP;
        end
      end
      RS_RESP: begin
        if (r_hs) begin
          rs_d = RS_IDLE;
        end
      end
      default: begin
        rs_d = RS_IDLE;
      end
    endcase
  end

  wire [IDX_W-1:0] r_idx    = s_axi_araddr[ADDR_W-1:2];
  wire             r_ctrl   = (r_idx == IDX_CTRL);
  wire             r_cnt    = (r_idx == IDX_CNT);
  wire             r_stat   = (r_idx == IDX_STAT);
  wire             r_mask   = (r_idx == IDX_MASK);
  wire             r_mapped = r_ctrl || r_cnt || r_stat || r_mask;
  wire [7:0]       ctrl_rd  = GUARD_MASK | {1'b0, ctrl.cnt_wen, 1'b0, ctrl.ctrl_wen,
                                            1'b0, ctrl.run, 1'b0, ctrl.rst_flag};
  wire [7:0]       rd_byte  = r_ctrl ? ctrl_rd :
                              r_cnt  ? count :
                              r_stat ? {6'h00, stat_q} :
                              r_mask ? {6'h00, mask_q} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_q      <= RS_IDLE;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      rd_ctrl_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      if (ar_hs) begin
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= r_mapped ? RESP_OKAY : RESP_SLVERR;
        rd_ctrl_q <= r_ctrl;
      end
    end
  end

  // Sticky events; a status read clears them, but a new event wins.
  wire [IRQ_W-1:0] stat_ev  = {cnt_rej, ovf};
  wire [IRQ_W-1:0] stat_clr = (ar_hs && r_stat) ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}};

  assign stat_d = (stat_q & ~stat_clr) | stat_ev;
  assign mask_d = mask_wr ? wd[IRQ_W-1:0] : mask_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      mask_q <= RST_MASK;
      irq    <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq    <= |(stat_d & mask_d);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_cnt_wen_guard;
    ctrl_wr && wd[BIT_CNT_GUARD] |=> $stable(ctrl.cnt_wen);
  endproperty
  a_cnt_wen_guard: assert property (p_cnt_wen_guard)
    else $error("counter write enable changed with guard set");

  property p_cnt_wen_take;
    ctrl_wr && !wd[BIT_CNT_GUARD] |=> ctrl.cnt_wen == $past(wd[BIT_CNT_WEN]);
  endproperty
  a_cnt_wen_take: assert property (p_cnt_wen_take)
    else $error("counter write enable did not take written value");

  property p_cnt_write;
    cnt_wr |=> (ctrl.cnt_wen ? count == $past(wd) : stat_q[IRQ_REJ]);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("counter write not handled per its enable");

  property p_ctrl_wen_guard;
    ctrl_wr && wd[BIT_CTRL_GUARD] |=> $stable(ctrl.ctrl_wen);
  endproperty
  a_ctrl_wen_guard: assert property (p_ctrl_wen_guard)
    else $error("control write enable changed with guard set");

  property p_run_locked;
    !ctrl.ctrl_wen |=> $stable(ctrl.run);
  endproperty
  a_run_locked: assert property (p_run_locked)
    else $error("run bit changed while control writes disabled");

  property p_run_write;
    ctrl_wr && ctrl.ctrl_wen && !wd[BIT_RUN_GUARD] |=> ctrl.run == $past(wd[BIT_RUN]);
  endproperty
  a_run_write: assert property (p_run_write)
    else $error("run bit did not follow guarded write");

  property p_run_guard;
    ctrl_wr && wd[BIT_RUN_GUARD] |=> $stable(ctrl.run);
  endproperty
  a_run_guard: assert property (p_run_guard)
    else $error("run bit changed with guard set");

  property p_stopped;
    !ctrl.run && !cnt_load |=> $stable(count) && !ovf;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_counting;
    (ctrl.run && !cnt_load) [*8] ##1 (ctrl.run && !cnt_load) [*8]
      |=> count == $past(count, 16) + 8'h01;
  endproperty
  a_counting: assert property (p_counting)
    else $error("counter idle while running");

  property p_flag_set;
    ovf |=> flag_q && internal_reset ##1 !internal_reset;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("overflow did not set reset flag");

  property p_flag_pin_clr;
    !external_reset_pin_n && !ovf |=> !flag_q;
  endproperty
  a_flag_pin_clr: assert property (p_flag_pin_clr)
    else $error("reset pin did not clear reset flag");

  property p_flag_guard;
    ctrl_wr && wd[BIT_FLAG_GUARD] && !ovf && external_reset_pin_n |=> $stable(flag_q);
  endproperty
  a_flag_guard: assert property (p_flag_guard)
    else $error("reset flag changed with guard set");

  property p_guard_read;
    s_axi_rvalid && rd_ctrl_q |-> (s_axi_rdata[7:0] & GUARD_MASK) == GUARD_MASK;
  endproperty
  a_guard_read: assert property (p_guard_read)
    else $error("guard bit read back as zero");

  property p_irq_level;
    ##1 irq == |($past(stat_d) & $past(mask_d));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not match masked status");

endmodule

`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the guarded watchdog control register behind AXI4-Lite.
`default_nettype none

`define check_eq(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wdcg_pkg::*;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = '0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  logic              pin_n = 1'b0;
  logic              internal_reset;
  logic              irq;
  int                miscompares = 0;
  int                n_checks = 0;
  int                cycles = 0;
  logic [1:0]        wr_q[$];
  logic [33:0]       rd_q[$];
  logic [1:0]        exp_b;
  logic [33:0]       exp_r;
  logic              m_cwen, m_cten, m_run, m_flag;
  logic [7:0]        d;
  logic [3:0]        s;

  always #10 aclk = ~aclk;

  wdcg_top dut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (awaddr),
    .s_axi_awvalid        (awvalid),
    .s_axi_awready        (awready),
    .s_axi_wdata          (wdata),
    .s_axi_wstrb          (wstrb),
    .s_axi_wvalid         (wvalid),
    .s_axi_wready         (wready),
    .s_axi_bresp          (bresp),
    .s_axi_bvalid         (bvalid),
    .s_axi_bready         (bready),
    .s_axi_araddr         (araddr),
    .s_axi_arvalid        (arvalid),
    .s_axi_arready        (arready),
    .s_axi_rdata          (rdata),
    .s_axi_rresp          (rresp),
    .s_axi_rvalid         (rvalid),
    .s_axi_rready         (rready),
    .external_reset_pin_n (pin_n),
    .internal_reset       (internal_reset),
    .irq                  (irq)
  );

  function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  // Guard and enable conditions all use the enables as they stood before the write.
  function automatic void model_ctrl(input logic [7:0] v);
    if (m_cten && !v[3]) m_run = v[2];
    if (m_cten && !v[1] && !v[0]) m_flag = 1'b0;
    if (!v[7]) m_cwen = v[6];
    if (!v[5]) m_cten = v[4];
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_exp();
    return {24'h0, 1'b1, m_cwen, 1'b1, m_cten, 1'b1, m_run, 1'b1, m_flag};
  endfunction

  // Response monitor: each completed response is compared with the oldest note.
  always @(posedge aclk) begin
    // Pop first: the compare macro names its expected value twice.
    if (bvalid === 1'b1 && bready === 1'b1 && wr_q.size() > 0) begin
      exp_b = wr_q.pop_front();
      `check_eq(bresp, exp_b)
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) begin
      exp_r = rd_q.pop_front();
      `check_eq({rresp, rdata}, exp_r)
    end
  end

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                           input logic [STRB_W-1:0] st, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    wr_q.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ev,
                          input logic [1:0] er);
    rd_q.push_back({er, ev});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic wr_ctrl(input logic [7:0] v);
    model_ctrl(v);
    axi_write(ba(IDX_CTRL), {24'h0, v}, 4'hf, RESP_OKAY);
  endtask

  // A counter overflow must raise the reset pulse within 60 cycles of the wait.
  task automatic wait_ovf();
    int n;
    n = 0;
    while (internal_reset !== 1'b1 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    `check_eq(internal_reset, 1'b1)
    `check_eq(irq, 1'b1)
    m_flag = 1'b1;
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic test_done();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cut a hang short; the whole sequence needs well under this many cycles.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      $display("unexpected at %0t: run timed out", $time);
      test_done();
    end
  end

  initial begin
    void'($urandom(30629));
    m_cwen = RST_CNT_WEN;
    m_cten = RST_CTRL_WEN;
    m_run = RST_RUN;
    m_flag = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pin_n <= 1'b1;
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    axi_read(ba(IDX_MASK), 32'h0, RESP_OKAY);
    `check_eq(irq, 1'b0)
    end_test("reset");

    axi_write(ba(IDX_CNT), 32'h5a, 4'hf, RESP_OKAY);
    axi_read(ba(IDX_CNT), 32'h0, RESP_OKAY);
    axi_read(ba(IDX_STAT), 32'h2, RESP_OKAY);
    wr_ctrl(8'h40);
    axi_write(ba(IDX_CNT), 32'h5a, 4'hf, RESP_OKAY);
    repeat (40) @(posedge aclk);
    axi_read(ba(IDX_CNT), 32'h5a, RESP_OKAY);
    end_test("counter_guard");

    axi_write(ba(IDX_MASK), 32'h1, 4'hf, RESP_OKAY);
    wr_ctrl(8'hd0);
    wr_ctrl(8'hf6);
    axi_write(ba(IDX_CNT), 32'hff, 4'hf, RESP_OKAY);
    wait_ovf();
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    axi_read(ba(IDX_STAT), 32'h1, RESP_OKAY);
    @(posedge aclk);
    `check_eq(irq, 1'b0)
    pin_n <= 1'b0;
    @(posedge aclk);
    pin_n <= 1'b1;
    m_flag = 1'b0;
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    axi_write(ba(IDX_CNT), 32'hff, 4'hf, RESP_OKAY);
    wait_ovf();
    wr_ctrl(8'hfd);
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    wr_ctrl(8'hfc);
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    axi_read(ba(IDX_STAT), 32'h1, RESP_OKAY);
    wr_ctrl(8'hf0);
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    end_test("overflow_flag");

    // Writes without lane 0 must leave the register alone.
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      s = 4'($urandom);
      if (s[0]) model_ctrl(d);
      axi_write(ba(IDX_CTRL), {24'h0, d}, s, RESP_OKAY);
      axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    end
    end_test("random_guards");

    axi_write(ba(IDX_MASK), 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_read(ba(IDX_MASK), 32'h3, RESP_OKAY);
    wr_ctrl(8'h00);
    axi_write(ba(IDX_CNT), 32'h11, 4'hf, RESP_OKAY);
    `check_eq(irq, 1'b1)
    axi_write(ba(IDX_STAT), 32'h3, 4'hf, RESP_OKAY);
    axi_read(ba(IDX_STAT), 32'h2, RESP_OKAY);
    axi_read(ba(IDX_STAT), 32'h0, RESP_OKAY);
    axi_write(ba(16'hffb5), 32'h12, 4'hf, RESP_SLVERR);
    axi_read(ba(16'hffb5), 32'h0, RESP_SLVERR);
    axi_read(ba(IDX_CTRL), ctrl_exp(), RESP_OKAY);
    end_test("map");
    repeat (2) @(posedge aclk);
    test_done();
  end
endmodule

`default_nettype wire
